// ---- common/adc_frame_pkg.sv ----
// shared constants, states and carriers of the serial converter frame control
package adc_frame_pkg;
    // ************************************************
    // frame and counting
    // ************************************************
    localparam int RES_W = 12;
    localparam int FRAME_W = 16;
    localparam int PAD_W = FRAME_W - RES_W;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] SAMPLE_FIRST = 6'h04;
    localparam logic [CNT_W-1:0] SAMPLE_LAST = 6'h0f;
    localparam logic [CNT_W-1:0] XFER_END = 6'h10;
    localparam logic [CNT_W-1:0] CONV_SCLKS = 6'h1c;
    localparam logic [CNT_W-1:0] CONV_END = XFER_END + CONV_SCLKS;
    localparam logic [CNT_W-1:0] MUX_SHORT_MIN = 6'h04;
    localparam logic [CNT_W-1:0] MUX_SHORT_MAX = 6'h07;
    // ************************************************
    // converter values
    // ************************************************
    localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
    localparam logic [RES_W-1:0] TRIAL_MSB = 12'h800;
    localparam logic [PAD_W-1:0] PAD_BITS = 4'h0;
    localparam logic ANALOG_INPUT_ZERO = 1'b0;
    // ************************************************
    // state and carriers
    // ************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARM = 3'b001,
        ST_XFER = 3'b011,
        ST_CONV = 3'b010,
        ST_DOWN = 3'b110
    } frame_state_e;

    typedef struct packed {
        logic sclk;
        logic chip_select_n;
        logic frame_sync;
        logic comp_hi;
    } pins_s;
endpackage

// ---- verilog/serial_adc_frame_control.sv ----
// frame control of a 12-bit serial converter output port, with its result fifo
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// result fifo
// ************************************************
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire do_wr = wr_valid && wr_ready;
    wire do_rd = rd_valid && rd_ready;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    assign wr_ready = cnt_r != DEPTH[AW:0];
    assign rd_valid = cnt_r != '0;
    assign rd_data = mem[rp_r];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_r] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_r + AW'(do_wr);
            rp_r <= rp_r + AW'(do_rd);
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // result_fifo

// ************************************************
// frame control
// ************************************************
module serial_adc_frame_control
    import adc_frame_pkg::*;
#(
    parameter bit DUAL_CH = 1'b0,
    parameter bit FS_PIN_EN = 1'b1,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic frame_sync,
    input wire logic comp_hi,
    output logic sdo_o,
    output logic sdo_oe,
    output logic sample_en,
    output logic [RES_W-1:0] dac_code,
    output logic input_selector,
    output logic awake
);
    if (DUAL_CH && FS_PIN_EN) begin : g_mode_chk
        $error("the dual channel variant has no frame sync pin");
    end

    function automatic logic in_range(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lo,
                                      input logic [CNT_W-1:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // ************************************************
    // pin synchronisers and edges
    // ************************************************
    pins_s meta_r;
    pins_s sync_r;
    pins_s last_r;
    wire pins_s pin_now = '{sclk, chip_select_n, frame_sync, comp_hi};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '{1'b0, 1'b1, 1'b1, 1'b0};
            sync_r <= '{1'b0, 1'b1, 1'b1, 1'b0};
            last_r <= '{1'b0, 1'b1, 1'b1, 1'b0};
        end else begin
            meta_r <= pin_now;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // without the frame sync pin the line reads as tied high
    wire fs_lvl = FS_PIN_EN ? sync_r.frame_sync : 1'b1;
    wire fs_old = FS_PIN_EN ? last_r.frame_sync : 1'b1;
    wire sclk_fall = last_r.sclk && !sync_r.sclk;
    wire sclk_rise = !last_r.sclk && sync_r.sclk;
    wire cs_fall = last_r.chip_select_n && !sync_r.chip_select_n;
    wire cs_rise = !last_r.chip_select_n && sync_r.chip_select_n;
    wire fs_fall = fs_old && !fs_lvl;
    wire fs_rise = !fs_old && fs_lvl;
    wire cs_low = !sync_r.chip_select_n;

    // ************************************************
    // cycle events
    // ************************************************
    // select fall needs a prior high level seen by the sampler
    wire present_ev = cs_fall || (cs_low && fs_rise);
    wire cs_start = cs_fall && fs_lvl;
    wire fs_start = cs_low && fs_fall;

    frame_state_e st_r;
    frame_state_e st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic by_fs_r;
    logic [FRAME_W-1:0] shift_r;
    logic [RES_W-1:0] out_word_r;
    logic [RES_W-1:0] trial_r;
    logic [RES_W-1:0] dac_r;
    logic sdo_oe_r;
    logic sample_r;
    logic sel_r;
    logic awake_r;

    wire busy = st_r != ST_IDLE;
    wire end_ev = busy && (cs_rise || (by_fs_r && fs_rise));
    wire counting = (st_r == ST_XFER) || (st_r == ST_CONV && cnt_r != CONV_END);
    wire cnt_step = counting && sclk_fall;
    wire sar_step = st_r == ST_CONV && cnt_step && !cnt_nxt[0];
    wire conv_done = st_r == ST_CONV && cnt_r == CONV_END;
    wire fifo_wr_ready;
    wire fifo_rd_valid;
    wire [RES_W-1:0] fifo_rd_data;
    // an end event in the finishing cycle wins, so nothing is stored for a cut cycle
    wire push = conv_done && fifo_wr_ready && !end_ev;
    wire shift_ev = st_r == ST_XFER && sdo_oe_r && sclk_rise && cnt_r != CNT_ZERO;
    wire mux_short = in_range(cnt_r, MUX_SHORT_MIN, MUX_SHORT_MAX);
    wire mux_long = cnt_r > MUX_SHORT_MAX;
    wire sample_nxt = st_nxt == ST_XFER && in_range(cnt_nxt, SAMPLE_FIRST, SAMPLE_LAST);
    wire comp_keep = sync_r.comp_hi; // input above trial keeps the bit
    wire [RES_W-1:0] dac_step = (comp_keep ? dac_r : (dac_r & ~trial_r)) | (trial_r >> 1);

    assign cnt_nxt = (st_nxt != st_r && st_nxt == ST_XFER) ? CNT_ZERO :
                     cnt_step ? cnt_r + CNT_ONE : cnt_r;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (cs_start) begin
                    st_nxt = ST_XFER;
                end else if (present_ev) begin
                    st_nxt = ST_ARM;
                end
            end
            ST_ARM: begin
                if (cs_rise) begin
                    st_nxt = ST_IDLE;
                end else if (fs_start) begin
                    st_nxt = ST_XFER;
                end
            end
            ST_XFER: begin
                if (end_ev) begin
                    st_nxt = ST_IDLE;
                end else if (cnt_step && cnt_r + CNT_ONE == XFER_END) begin
                    st_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (end_ev) begin
                    st_nxt = ST_IDLE;
                end else if (push) begin
                    st_nxt = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (end_ev) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // ************************************************
    // sequencing registers
    // ************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            by_fs_r <= 1'b0;
            sample_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sample_r <= sample_nxt;
            if (st_r == ST_IDLE || st_r == ST_ARM) begin
                by_fs_r <= fs_start;
            end
        end
    end

    // output shifter: the word loaded here is last cycle's result
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= '0;
            sdo_oe_r <= 1'b0;
            out_word_r <= CODE_ZERO;
        end else begin
            if (st_r == ST_IDLE && fifo_rd_valid) begin
                out_word_r <= fifo_rd_data;
            end
            if (st_r == ST_IDLE && present_ev) begin
                shift_r <= {out_word_r, PAD_BITS};
                sdo_oe_r <= 1'b1;
            end else if (end_ev || (st_r == ST_XFER && st_nxt != ST_XFER)) begin
                sdo_oe_r <= 1'b0;
            end else if (shift_ev) begin
                shift_r <= {shift_r[FRAME_W-2:0], 1'b0};
            end
        end
    end

    // successive approximation, one decision per two serial clocks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dac_r <= CODE_ZERO;
            trial_r <= CODE_ZERO;
        end else if (st_r == ST_XFER && st_nxt == ST_CONV) begin
            dac_r <= TRIAL_MSB;
            trial_r <= TRIAL_MSB;
        end else if (sar_step && trial_r != CODE_ZERO) begin
            dac_r <= dac_step;
            trial_r <= trial_r >> 1;
        end
    end

    // power follows the cycle; wake is judged at a falling clock edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            awake_r <= 1'b0;
        end else if (st_nxt == ST_DOWN || st_nxt == ST_IDLE) begin
            awake_r <= 1'b0;
        end else if (sclk_fall && (st_r == ST_ARM || st_r == ST_XFER)) begin
            awake_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_r <= ANALOG_INPUT_ZERO;
        end else if (DUAL_CH && end_ev && st_r != ST_ARM) begin
            if (mux_short) begin
                sel_r <= ANALOG_INPUT_ZERO;
            end else if (mux_long) begin
                sel_r <= !sel_r;
            end
        end
    end

    // a full fifo holds the finished conversion in ST_CONV until an end event, which drops it
    result_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(nrst),
        .wr_valid(push),
        .wr_ready(fifo_wr_ready),
        .wr_data(dac_r),
        .rd_valid(fifo_rd_valid),
        .rd_ready(st_r == ST_IDLE),
        .rd_data(fifo_rd_data)
    );

    assign sdo_o = shift_r[FRAME_W-1];
    assign sdo_oe = sdo_oe_r;
    assign sample_en = sample_r;
    assign dac_code = dac_r;
    assign input_selector = sel_r;
    assign awake = awake_r;

    // ************************************************
    // checks
    // ************************************************
    sequence s_sel_end;
        DUAL_CH && end_ev && st_r != ST_ARM;
    endsequence

    property p_idle_hiz;
        @(posedge ref_clk) disable iff (!nrst) sync_r.chip_select_n && last_r.chip_select_n |-> !sdo_oe_r;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("data driven while select high");

    property p_release;
        @(posedge ref_clk) disable iff (!nrst) st_r == ST_XFER && st_nxt == ST_CONV |=> !sdo_oe_r && st_r == ST_CONV;
    endproperty
    a_release: assert property (p_release) else $error("data not released after clock 16");

    property p_shift_rise;
        @(posedge ref_clk) disable iff (!nrst) sdo_oe_r && $past(sdo_oe_r) && $changed(shift_r) |-> $past(sclk_rise);
    endproperty
    a_shift_rise: assert property (p_shift_rise) else $error("data moved off a rising edge");

    property p_sample_win;
        @(posedge ref_clk) disable iff (!nrst) sample_r |-> cnt_r >= SAMPLE_FIRST && cnt_r <= SAMPLE_LAST;
    endproperty
    a_sample_win: assert property (p_sample_win) else $error("sampling outside clocks 5 to 16");

    property p_conv_len;
        @(posedge ref_clk) disable iff (!nrst) push |-> cnt_r == XFER_END + CONV_SCLKS && trial_r == CODE_ZERO;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("result pushed at wrong count");

    property p_abort;
        @(posedge ref_clk) disable iff (!nrst) st_r == ST_CONV && end_ev |=> st_r == ST_IDLE && !push;
    endproperty
    a_abort: assert property (p_abort) else $error("early rise did not abort");

    property p_down;
        @(posedge ref_clk) disable iff (!nrst) push |=> st_r == ST_DOWN && !awake_r;
    endproperty
    a_down: assert property (p_down) else $error("no low power after conversion");

    property p_mux_reset;
        @(posedge ref_clk) disable iff (!nrst) s_sel_end and mux_short |=> sel_r == ANALOG_INPUT_ZERO;
    endproperty
    a_mux_reset: assert property (p_mux_reset) else $error("short cycle kept channel");

    property p_mux_toggle;
        @(posedge ref_clk) disable iff (!nrst) s_sel_end and mux_long |=> sel_r != $past(sel_r);
    endproperty
    a_mux_toggle: assert property (p_mux_toggle) else $error("long cycle did not toggle channel");
endmodule // serial_adc_frame_control

`default_nettype wire

// ---- tb/host_model.sv ----
// host side model: serial clock, chip select, frame sync and the analog comparator
`timescale 1ns/1ps
`default_nettype none

module host_model
    import adc_frame_pkg::*;
(
    input wire logic [RES_W-1:0] vin,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic sample_en,
    input wire logic awake,
    input wire logic [RES_W-1:0] dac_code,
    output var logic sclk,
    output var logic chip_select_n,
    output var logic frame_sync,
    output logic comp_hi
);
    logic last_q;
    logic sdo_line;
    logic [FRAME_W-1:0] word;
    logic oe_q [1:44];
    logic se_q [1:44];
    logic awake_q;
    logic [RES_W-1:0] dac17;

    // a released line shows the inverse of its last bit, so a stale value never passes
    assign sdo_line = sdo_oe ? sdo_o : ~last_q;
    // input code v means the level lies above every trial code up to v
    assign comp_hi = (dac_code <= vin);

    always @(negedge sdo_oe) last_q = sdo_o;

    initial begin
        last_q = 1'b0;
        sclk = 1'b0;
        chip_select_n = 1'b1;
        frame_sync = 1'b1;
    end

    // ************************************************
    // link sequences, every delay a multiple of 100 ns
    // ************************************************
    task automatic idle(input int n, input logic fs_lvl);
        chip_select_n = 1'b1;
        frame_sync = fs_lvl;
        repeat (n) begin
            sclk = 1'b1; // at least one falling edge while deselected
            #400;
            sclk = 1'b0;
            #400;
        end
    endtask

    // clock idles low, data taken after each falling edge
    task automatic run_frame(input logic fs_mode, input int nclk);
        chip_select_n = 1'b0;
        #400;
        if (fs_mode) begin
            frame_sync = 1'b1;
            #400;
        end
        for (int k = 1; k <= nclk; k++) begin
            sclk = 1'b1;
            #100;
            if (fs_mode && k == 1) begin
                frame_sync = 1'b0; // sync drops while the clock is high
            end
            #300;
            sclk = 1'b0;
            #200;
            if (k <= FRAME_W) begin
                word[FRAME_W-k] = sdo_line;
            end
            oe_q[k] = sdo_oe;
            se_q[k] = sample_en;
            if (k == 2) begin
                awake_q = awake;
            end
            if (k == 17) begin
                dac17 = dac_code;
            end
            #200;
        end
        #400;
        chip_select_n = 1'b1; // held low until conversion is done, unless aborting
    endtask
endmodule // host_model

`default_nettype wire

// ---- tb/serial_adc_frame_control_tb.sv ----
// self-checking bench of the serial converter frame control
`timescale 1ns/1ps
`default_nettype none

module serial_adc_frame_control_tb;
    import adc_frame_pkg::*;

    logic ref_clk;
    logic nrst;
    logic sclk;
    logic chip_select_n;
    logic frame_sync;
    logic comp_hi;
    logic sdo_o;
    logic sdo_oe;
    logic sample_en;
    logic [RES_W-1:0] dac_code;
    logic input_selector;
    logic awake;
    logic [RES_W-1:0] vin;
    logic dual_sel;
    logic exp_sel;
    int fails;
    int total_checks;

    serial_adc_frame_control #(.DUAL_CH(1'b0), .FS_PIN_EN(1'b1), .FIFO_DEPTH(32)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
        .frame_sync(frame_sync), .comp_hi(comp_hi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .sample_en(sample_en), .dac_code(dac_code), .input_selector(input_selector), .awake(awake)
    );

    // the dual channel variant watches the same link; only its selector is judged
    serial_adc_frame_control #(.DUAL_CH(1'b1), .FS_PIN_EN(1'b0), .FIFO_DEPTH(32)) u_dual (
        .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
        .frame_sync(frame_sync), .comp_hi(comp_hi), .sdo_o(), .sdo_oe(),
        .sample_en(), .dac_code(), .input_selector(dual_sel), .awake()
    );

    host_model u_host (
        .vin(vin), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sample_en(sample_en), .awake(awake),
        .dac_code(dac_code), .sclk(sclk), .chip_select_n(chip_select_n),
        .frame_sync(frame_sync), .comp_hi(comp_hi)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one cycle: the word read must be the result of the cycle before
    task automatic do_frame(input logic fs_mode, input int nclk, input logic [RES_W-1:0] v,
                            input logic [RES_W-1:0] exp_word);
        vin = v;
        u_host.idle(2, ~fs_mode);
        check(16'(sdo_oe), 16'h0000, "output driven while deselected");
        check(16'(dual_sel), 16'(exp_sel), "dual channel selector");
        u_host.run_frame(fs_mode, nclk);
        if (nclk > 7) begin
            exp_sel = ~exp_sel;
        end
        check(u_host.word, {exp_word, PAD_BITS}, "frame word");
        check(16'(u_host.oe_q[1]), 16'h0001, "output not driven at first fall");
        check(16'(u_host.oe_q[16]), 16'h0001, "output released early");
        check(16'(u_host.oe_q[17]), 16'h0000, "output held past bit 16");
        check(16'(u_host.se_q[4]), 16'h0000, "sampling before fifth clock");
        check(16'(u_host.se_q[5]), 16'h0001, "no sampling at fifth clock");
        check(16'(u_host.se_q[16]), 16'h0001, "sampling shorter than 12");
        check(16'(u_host.se_q[17]), 16'h0000, "sampling longer than 12");
        check(16'(u_host.awake_q), 16'h0001, "not woken by cycle start");
        check(16'(u_host.dac17), 16'(TRIAL_MSB), "first trial code");
        if (nclk >= 44) begin
            check(16'(dac_code), 16'(v), "converted code");
            check(16'(awake), 16'h0000, "awake after conversion");
        end
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset;
        check(16'(sdo_oe), 16'h0000, "output enable after reset");
        check(16'(awake), 16'h0000, "awake after reset");
        check(16'(sample_en), 16'h0000, "sampling after reset");
        check(16'(dac_code), 16'(CODE_ZERO), "code after reset");
        $display("test reset done");
    endtask

    task automatic t_codes;
        do_frame(1'b0, 44, 12'hfff, 12'h000);
        do_frame(1'b0, 44, 12'h000, 12'hfff);
        do_frame(1'b0, 44, 12'ha5c, 12'h000);
        $display("test end codes done");
    endtask

    task automatic t_sync_modes;
        do_frame(1'b1, 44, 12'h3c1, 12'ha5c);
        do_frame(1'b0, 44, 12'h123, 12'h3c1);
        do_frame(1'b1, 44, 12'h801, 12'h123);
        $display("test sync modes done");
    endtask

    // an early release drops the result, so the older word repeats
    task automatic t_abort;
        do_frame(1'b0, 30, 12'h7e7, 12'h801);
        do_frame(1'b1, 44, 12'h0f0, 12'h801);
        do_frame(1'b0, 44, 12'h555, 12'h0f0);
        $display("test abort done");
    endtask

    // a select pulse of five clocks sends the dual selector back to input zero
    task automatic t_mux;
        u_host.idle(2, 1'b1);
        check(16'(dual_sel), 16'h0001, "selector before short cycle");
        u_host.run_frame(1'b0, 5);
        u_host.idle(2, 1'b1);
        check(16'(dual_sel), 16'(ANALOG_INPUT_ZERO), "selector after short cycle");
        $display("test mux reset done");
    endtask

    initial begin
        nrst = 1'b0;
        vin = CODE_ZERO;
        exp_sel = ANALOG_INPUT_ZERO;
        fails = 0;
        total_checks = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #30;
        t_reset();
        t_codes();
        t_sync_modes();
        t_abort();
        t_mux();
        close_out();
    end

    // the whole run needs well under this; running out means a hang
    initial begin
        #3000000;
        fails++;
        $display("mismatch at %0t: run did not finish", $time);
        close_out();
    end
endmodule // serial_adc_frame_control_tb

`default_nettype wire
